//--- hdl/iocdma_card.sv
// Contract
// [RL1] Software enables each channel by its own bit in write register 3 before any request.
// [RL2] An enabled channel with an internal request pulls its request line low.
// [RL3] The data buffer is enabled while either channel grant is asserted.
// [RL4] In register cycles the buffer direction follows the read/not-write line.
// [RL5] In DMA cycles the buffer direction is the inverse of read/not-write.
// [RL6] The ready strobe uses the same delay scheme as the register transfer ack.
// [RL7] With read/not-write high the ready delay starts at once.
// [RL8] With read/not-write low the delay waits for the memory's transfer ack.
// [RL9] The delay covers the register setup time plus a 30 ns bus margin.
// [RL10] The card may watch the controller's completion line for block end.
// [RL11] Strobe and buffer drop once the channel grant is withdrawn.
`timescale 1ns/1ps
`include "iocdma_cfg.svh"

module iocdma_card (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // per-channel enables from card write register 3
  input  wire iocdma_pkg::iocdma_chan_t i_chan_xfer_allow,
  // card-side requests and data
  input  wire logic                 i_tx_valid,
  input  wire iocdma_pkg::iocdma_word_t i_tx_data,
  output logic                      o_tx_ready,
  input  wire logic                 i_rx_request,
  output iocdma_pkg::iocdma_word_t  o_rx_data,
  output logic                      o_rx_valid,
  output logic                      o_block_done,
  // backplane pins
  input  wire iocdma_pkg::iocdma_chan_t i_chan_xfer_grant_n,
  input  wire logic                 i_bus_read_not_write,
  input  wire logic                 i_reg_strobe_n,
  input  wire logic                 i_transfer_ack_n,
  input  wire logic                 i_dma_done_n,
  input  wire iocdma_pkg::iocdma_word_t i_bus_data,
  output iocdma_pkg::iocdma_word_t  o_bus_data,
  output logic                      o_bus_data_oe,
  output logic                      o_chan0_xfer_request_n,
  output logic                      o_chan1_xfer_request_n,
  output logic                      o_buf_enable,
  output logic                      o_buf_to_bus,
  output logic                      o_xfer_ready_strobe_n,
  output logic                      o_transfer_ack_n,
  output logic                      o_transfer_ack_oe
);
  import iocdma_pkg::*;

  // ****************************************************************
  // constants
  // ****************************************************************
  // delay length in cycles, at least one
  localparam iocdma_cnt_t DELAY_CYC =
    iocdma_cnt_t'((`IOCDMA_DELAY_CYC < 1) ? 1 : `IOCDMA_DELAY_CYC);
  localparam int SYNC_W = 2 + 4 + `IOCDMA_DATA_W;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] meta_q, meta_d;
  logic [SYNC_W-1:0] sync_q, sync_d;

  iocdma_chan_t s_grant_n;
  logic         s_rnw;
  logic         s_reg_n;
  logic         s_ack_n;
  logic         s_done_n;
  iocdma_word_t s_data;

  // every pin passes two flops; only sync_q is read below
  always_comb begin
    meta_d = {i_chan_xfer_grant_n, i_bus_read_not_write,
              i_reg_strobe_n, i_transfer_ack_n, i_dma_done_n,
              i_bus_data};
    sync_d = meta_q;
  end

  // idle levels keep the card quiet during reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= {6'h3f, {`IOCDMA_DATA_W{1'b0}}};
      sync_q <= {6'h3f, {`IOCDMA_DATA_W{1'b0}}};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign {s_grant_n, s_rnw, s_reg_n, s_ack_n, s_done_n, s_data} = sync_q;

  // ****************************************************************
  // outbound word buffer
  // ****************************************************************
  iocdma_stream_if #(.W(`IOCDMA_DATA_W)) tx_in ();
  iocdma_stream_if #(.W(`IOCDMA_DATA_W)) tx_out ();

  logic pop;

  assign tx_in.data   = i_tx_data;
  assign tx_in.valid  = i_tx_valid;
  assign o_tx_ready   = tx_in.ready;  // registered inside the fifo
  assign tx_out.ready = pop;

  // stalls the source once all 32 words are held
  iocdma_fifo #(
    .W     (`IOCDMA_DATA_W),
    .DEPTH (`IOCDMA_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .s_in  (tx_in),
    .s_out (tx_out)
  );

  // ****************************************************************
  // handshake sequencer
  // ****************************************************************
  iocdma_state_t st_q, st_d;
  iocdma_cnt_t   cnt_q, cnt_d;
  logic          dma_q, dma_d;      // cycle is a dma cycle
  logic          rnw_q, rnw_d;      // read/not-write latched at start
  iocdma_word_t  rx_data_q, rx_data_d;
  logic          rx_valid_q, rx_valid_d;
  logic          grant_act;
  logic          active;

  // either grant low means a dma cycle for this card
  assign grant_act = ~&s_grant_n;
  // what keeps the current cycle open
  assign active    = dma_q ? grant_act : ~s_reg_n;

  // next state; grant beats a register strobe if both appear
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    dma_d      = dma_q;
    rnw_d      = rnw_q;
    rx_data_d  = rx_data_q;
    rx_valid_d = 1'b0;
    pop        = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (grant_act) begin
          dma_d = 1'b1;
          rnw_d = s_rnw;
          // high: start now; low: wait for memory ack
          st_d  = s_rnw ? ST_DELAY : ST_WAIT_ACK;      // [RL7] [RL8]
        end else if (!s_reg_n) begin
          dma_d = 1'b0;
          rnw_d = s_rnw;
          st_d  = ST_DELAY;                             // [RL6]
        end
      end
      ST_WAIT_ACK: begin
        if (!active) begin
          st_d = ST_IDLE;                               // [RL11]
        end else if (!s_ack_n) begin
          st_d = ST_DELAY;                              // [RL8]
        end
      end
      ST_DELAY: begin
        if (!active) begin
          st_d = ST_IDLE;                               // [RL11]
        end else if (cnt_q == DELAY_CYC - 1'b1) begin
          st_d      = ST_READY;                         // [RL9]
          rx_data_d = s_data;
        end else begin
          cnt_d = iocdma_cnt_t'(cnt_q + 1'b1);
        end
      end
      ST_READY: begin
        // one word moves per granted cycle, at its close
        if (!active) begin
          st_d = ST_IDLE;                               // [RL11]
          if (dma_q && !rnw_q) begin
            pop = 1'b1;
          end
          if (dma_q && rnw_q) begin
            rx_valid_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q       <= ST_IDLE;
      cnt_q      <= '0;
      dma_q      <= 1'b0;
      rnw_q      <= 1'b0;
      rx_data_q  <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      dma_q      <= dma_d;
      rnw_q      <= rnw_d;
      rx_data_q  <= rx_data_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  assign o_rx_data  = rx_data_q;
  assign o_rx_valid = rx_valid_q;

  // ****************************************************************
  // backplane outputs
  // ****************************************************************
  logic         req0_n_q, req0_n_d;
  logic         req1_n_q, req1_n_d;
  logic         buf_en_q, buf_en_d;
  logic         to_bus_q, to_bus_d;
  logic         oe_q, oe_d;
  iocdma_word_t bus_data_q, bus_data_d;
  logic         rdy_n_q, rdy_n_d;
  logic         ack_oe_q, ack_oe_d;
  logic         done_prev_q, done_prev_d;
  logic         done_q, done_d;

  // ready and ack outputs follow next state so the pins need no extra gates
  always_comb begin
    // requests gated by the software enables
    req0_n_d = ~(i_chan_xfer_allow[0] & tx_out.valid);   // [RL1] [RL2]
    req1_n_d = ~(i_chan_xfer_allow[1] & i_rx_request);   // [RL1] [RL2]
    // buffer open for a grant or a register strobe
    buf_en_d = grant_act | ~s_reg_n;                     // [RL3] [RL11]
    // dma turns the line round since it describes memory
    to_bus_d = grant_act ? ~s_rnw : s_rnw;               // [RL4] [RL5]
    // only dma words come from the fifo
    oe_d       = grant_act & ~s_rnw & tx_out.valid;
    bus_data_d = tx_out.data;
    // same delay drives the dma ready strobe and the register ack
    rdy_n_d  = ~((st_d == ST_READY) & dma_d);            // [RL6]
    ack_oe_d = (st_d == ST_READY) & ~dma_d;              // [RL6]
    // completion edge; optional for software
    done_prev_d = s_done_n;
    done_d      = done_prev_q & ~s_done_n;               // [RL10]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req0_n_q    <= 1'b1;
      req1_n_q    <= 1'b1;
      buf_en_q    <= 1'b0;
      to_bus_q    <= 1'b0;
      oe_q        <= 1'b0;
      bus_data_q  <= '0;
      rdy_n_q     <= 1'b1;
      ack_oe_q    <= 1'b0;
      done_prev_q <= 1'b1;
      done_q      <= 1'b0;
    end else begin
      req0_n_q    <= req0_n_d;
      req1_n_q    <= req1_n_d;
      buf_en_q    <= buf_en_d;
      to_bus_q    <= to_bus_d;
      oe_q        <= oe_d;
      bus_data_q  <= bus_data_d;
      rdy_n_q     <= rdy_n_d;
      ack_oe_q    <= ack_oe_d;
      done_prev_q <= done_prev_d;
      done_q      <= done_d;
    end
  end

  assign o_chan0_xfer_request_n = req0_n_q;
  assign o_chan1_xfer_request_n = req1_n_q;
  assign o_buf_enable           = buf_en_q;
  assign o_buf_to_bus           = to_bus_q;
  assign o_bus_data_oe          = oe_q;
  assign o_bus_data             = bus_data_q;
  assign o_xfer_ready_strobe_n  = rdy_n_q;
  // open drain: pulls low only while enabled
  assign o_transfer_ack_n       = 1'b0;
  assign o_transfer_ack_oe      = ack_oe_q;
  assign o_block_done           = done_q;
endmodule

//--- inc/iocdma_cfg.svh
`ifndef IOCDMA_CFG_SVH
`define IOCDMA_CFG_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
// system clock rate in MHz (10 ns period)
`define IOCDMA_CLK_MHZ        100
// longest register read or setup time on the card side
`define IOCDMA_REG_SETUP_NS   50
// data setup margin on the bus before the strobe falls
`define IOCDMA_BUS_MARGIN_NS  30
// least delay, rounded up to whole cycles
`define IOCDMA_DELAY_CYC      (((`IOCDMA_REG_SETUP_NS + \
  `IOCDMA_BUS_MARGIN_NS) * `IOCDMA_CLK_MHZ + 999) / 1000)

// ****************************************************************
// data path
// ****************************************************************
`define IOCDMA_DATA_W         16
`define IOCDMA_FIFO_DEPTH     32
`define IOCDMA_CHANS          2

`endif

//--- inc/iocdma_pkg.sv
`include "iocdma_cfg.svh"

package iocdma_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [`IOCDMA_DATA_W-1:0] iocdma_word_t;
  typedef logic [`IOCDMA_CHANS-1:0]  iocdma_chan_t;
  typedef logic [7:0]                iocdma_cnt_t;

  // handshake sequencer states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_WAIT_ACK = 2'b01,
    ST_DELAY    = 2'b10,
    ST_READY    = 2'b11
  } iocdma_state_t;

endpackage

//--- inc/iocdma_stream_if.sv
`timescale 1ns/1ps

// ****************************************************************
// valid/ready word stream
// ****************************************************************
interface iocdma_stream_if #(
  parameter int W = 16
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  // producer side
  modport src (output data, output valid, input ready);
  // consumer side
  modport snk (input data, input valid, output ready);
endinterface

//--- hdl/iocdma_fifo.sv
`timescale 1ns/1ps

// ****************************************************************
// flip-flop fifo, registered flags
// ****************************************************************
module iocdma_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  iocdma_stream_if.snk    s_in,
  iocdma_stream_if.src    s_out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          in_rdy_q, in_rdy_d, out_vld_q, out_vld_d;
  logic          push, pop;

  assign s_in.ready  = in_rdy_q;
  assign s_out.valid = out_vld_q;
  assign s_out.data  = mem_q[rd_q];

  // next pointers, count and flags
  always_comb begin
    push      = s_in.valid & in_rdy_q;
    pop       = s_out.ready & out_vld_q;
    wr_d      = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d      = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    in_rdy_d  = cnt_d != (AW+1)'(DEPTH);   // honest full
    out_vld_d = cnt_d != '0;               // honest empty
  end

  // state registers; storage has no reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_rdy_q  <= 1'b0;
      out_vld_q <= 1'b0;
    end else begin
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      cnt_q     <= cnt_d;
      in_rdy_q  <= in_rdy_d;
      out_vld_q <= out_vld_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= s_in.data;
    end
  end
endmodule

//--- test/iocdma_card_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker for the dma handshake card
// ****************************************************************
module iocdma_card_checker (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [1:0] i_chan_xfer_allow,
  input wire logic [1:0] i_chan_xfer_grant_n,
  input wire logic       i_bus_read_not_write,
  input wire logic       i_reg_strobe_n,
  input wire logic       i_transfer_ack_n,
  input wire logic       o_chan0_xfer_request_n,
  input wire logic       o_buf_enable,
  input wire logic       o_buf_to_bus,
  input wire logic       o_xfer_ready_strobe_n,
  input wire logic       o_transfer_ack_oe
);
  logic [7:0] grant_q, reg_q, ack_q, quiet_q;
  logic [7:0] grant_d, reg_d, ack_d, quiet_d;
  logic       idle;
  // saturating run length, so a long idle stretch never wraps to zero
  function automatic logic [7:0] run(input logic c, input logic [7:0] n);
    return c ? n + {7'h00, n != 8'hff} : 8'h00;
  endfunction
  // cycles each pin condition has held, pins seen as they stand
  always_comb begin
    idle    = &i_chan_xfer_grant_n;
    grant_d = run(!idle, grant_q);
    reg_d   = run(idle & !i_reg_strobe_n, reg_q);
    ack_d   = run(!i_transfer_ack_n, ack_q);
    quiet_d = run(idle & i_reg_strobe_n, quiet_q);
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {grant_q, reg_q, ack_q, quiet_q} <= 32'h0000_0000;
    end else begin
      {grant_q, reg_q, ack_q, quiet_q} <= {grant_d, reg_d, ack_d, quiet_d};
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // counts below: two sync flops, eight delay cycles, one register
  chk_req_gated: assert property (
    !$past(i_chan_xfer_allow[0]) |-> o_chan0_xfer_request_n)
    else $error("channel 0 request while disabled");
  chk_buf_grant: assert property (
    grant_q >= 8'd4 |-> o_buf_enable)
    else $error("buffer off during a grant");
  chk_reg_dir: assert property (
    reg_q >= 8'd5 |-> o_buf_to_bus == $past(i_bus_read_not_write, 3))
    else $error("register cycle buffer direction");
  chk_dma_dir: assert property (
    grant_q >= 8'd5 |-> o_buf_to_bus == !$past(i_bus_read_not_write, 3))
    else $error("dma cycle buffer direction");
  chk_ack_delay: assert property (
    $rose(o_transfer_ack_oe) && grant_q == 8'h00 |-> reg_q == 8'd11)
    else $error("register ack delay");
  chk_in_delay: assert property (
    $fell(o_xfer_ready_strobe_n) && $past(i_bus_read_not_write, 3)
      |-> grant_q == 8'd11)
    else $error("input ready delay");
  chk_out_delay: assert property (
    $fell(o_xfer_ready_strobe_n) && !$past(i_bus_read_not_write, 3)
      |-> ack_q == 8'd11)
    else $error("output ready delay");
  chk_release: assert property (
    quiet_q >= 8'd3 |-> o_xfer_ready_strobe_n && !o_buf_enable
      && !o_transfer_ack_oe)
    else $error("strobe or buffer held after release");
endmodule
bind iocdma_card iocdma_card_checker u_chk (
  .i_clk, .i_rst, .i_chan_xfer_allow, .i_chan_xfer_grant_n,
  .i_bus_read_not_write, .i_reg_strobe_n, .i_transfer_ack_n,
  .o_chan0_xfer_request_n, .o_buf_enable, .o_buf_to_bus,
  .o_xfer_ready_strobe_n, .o_transfer_ack_oe
);

//--- test/iocdma_dmac_model.sv
`timescale 1ns/1ps
// ****************************************************************
// backplane controller, memory and processor, behavioural
// ****************************************************************
module iocdma_dmac_model (
  input  wire logic        i_clk,
  input  wire logic [1:0]  i_request_n,
  input  wire logic        i_ready_n,
  input  wire logic        i_ack_n,
  input  wire logic [15:0] i_bus,
  output logic      [1:0]  o_grant_n,
  output logic             o_rnw,
  output logic             o_reg_strobe_n,
  output logic             o_ack_n,
  output logic             o_done_n,
  output logic      [15:0] o_bus
);
  bit drv = 1'b0;  // memory drives the data lines
  initial begin
    {o_grant_n, o_rnw, o_reg_strobe_n, o_ack_n, o_done_n} = 6'h3f;
    o_bus = 16'h0000;
  end
  // a bus nobody drives flips each cycle instead of holding a value;
  // flipped on the rising edge so it never races the negedge driver
  always @(posedge i_clk) begin
    if (!drv) o_bus <= ~o_bus;
  end
  // one granted word; memory stalls ack_wait cycles on output cycles
  task automatic xfer(input int ch, input logic rnw, input int ack_wait,
    input logic [15:0] wr, output logic [15:0] got, output bit ok);
    int n;
    n = 0;
    while (i_request_n[ch] !== 1'b0 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    o_rnw = rnw;
    o_grant_n[ch] = 1'b0;
    // memory holds its word for the whole granted cycle
    drv = rnw;
    if (rnw) o_bus = wr;
    if (!rnw) begin
      repeat (ack_wait) @(negedge i_clk);
      o_ack_n = 1'b0;
    end
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ready_n !== 1'b0 && n < 60);
    got = i_bus;
    ok = (n < 60);
    @(negedge i_clk);
    {o_grant_n, o_ack_n} = 3'h7;
    drv = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  // grant taken back before the card can answer
  task automatic cut(input int ch, input int len);
    o_rnw = 1'b1;
    o_grant_n[ch] = 1'b0;
    repeat (len) @(negedge i_clk);
    o_grant_n = 2'b11;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic reg_cycle(input logic rnw, output bit ok);
    int n;
    o_rnw = rnw;
    o_reg_strobe_n = 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack_n !== 1'b0 && n < 60);
    ok = (n < 60);
    @(negedge i_clk);
    o_reg_strobe_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic finish_block;
    o_done_n = 1'b0;
    repeat (4) @(negedge i_clk);
    o_done_n = 1'b1;
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import iocdma_pkg::*;
  logic i_clk, i_rst, i_tx_valid, i_rx_request, i_reg_strobe_n, m_ack_n;
  logic i_bus_read_not_write, i_transfer_ack_n, i_dma_done_n, o_tx_ready;
  logic o_rx_valid, o_block_done, o_bus_data_oe, o_chan0_xfer_request_n;
  logic o_chan1_xfer_request_n, o_buf_enable, o_buf_to_bus;
  logic o_xfer_ready_strobe_n, o_transfer_ack_n, o_transfer_ack_oe;
  iocdma_chan_t i_chan_xfer_allow, i_chan_xfer_grant_n;
  iocdma_word_t i_tx_data, i_bus_data, o_bus_data, o_rx_data, m_bus;
  iocdma_word_t rx_seen, w, got;
  iocdma_word_t q[$];
  int n_fail = 0, samples_checked = 0, rx_cnt = 0, done_cnt = 0, n, seed;
  bit ok;
  // wired pins: card data wins while it drives, ack is open-drain
  assign i_bus_data = o_bus_data_oe ? o_bus_data : m_bus;
  assign i_transfer_ack_n = m_ack_n & ~(o_transfer_ack_oe & ~o_transfer_ack_n);
  iocdma_card uut (
    .i_clk, .i_rst, .i_chan_xfer_allow, .i_tx_valid, .i_tx_data, .o_tx_ready,
    .i_rx_request, .o_rx_data, .o_rx_valid, .o_block_done,
    .i_chan_xfer_grant_n, .i_bus_read_not_write, .i_reg_strobe_n,
    .i_transfer_ack_n, .i_dma_done_n, .i_bus_data, .o_bus_data,
    .o_bus_data_oe, .o_chan0_xfer_request_n, .o_chan1_xfer_request_n,
    .o_buf_enable, .o_buf_to_bus, .o_xfer_ready_strobe_n, .o_transfer_ack_n,
    .o_transfer_ack_oe
  );
  iocdma_dmac_model dmac (
    .i_clk,
    .i_request_n    ({o_chan1_xfer_request_n, o_chan0_xfer_request_n}),
    .i_ready_n      (o_xfer_ready_strobe_n),
    .i_ack_n        (i_transfer_ack_n),
    .i_bus          (i_bus_data),
    .o_grant_n      (i_chan_xfer_grant_n),
    .o_rnw          (i_bus_read_not_write),
    .o_reg_strobe_n (i_reg_strobe_n),
    .o_ack_n        (m_ack_n),
    .o_done_n       (i_dma_done_n),
    .o_bus          (m_bus)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // one-cycle pulses are caught here so no task can step over them
  always @(posedge i_clk) begin
    if (o_rx_valid === 1'b1) begin
      rx_seen <= o_rx_data;
      rx_cnt <= rx_cnt + 1;
    end
    if (o_block_done === 1'b1) done_cnt <= done_cnt + 1;
  end
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {i_rst, i_tx_valid, i_rx_request} = 3'b100;
    i_chan_xfer_allow = 2'b00;
    i_tx_data = 16'h0000;
    seed = $urandom(84);
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    check("reset outputs", 16'({o_chan0_xfer_request_n, o_chan1_xfer_request_n,
      o_xfer_ready_strobe_n, o_buf_enable, o_transfer_ack_oe}), 16'h1c);
    // fill with both channels off until the fifo refuses
    @(negedge i_clk);
    n = 0;
    while (o_tx_ready === 1'b1 && n < 40) begin
      w = (n == 0) ? 16'h0000 : (n == 1) ? 16'hffff : 16'($urandom);
      {i_tx_valid, i_tx_data} = {1'b1, w};
      q.push_back(w);
      n++;
      @(negedge i_clk);
    end
    i_tx_valid = 1'b0;
    check("words accepted", 16'(n), 16'd32);
    check("request 0 while off", 16'(o_chan0_xfer_request_n), 16'h1);
    i_chan_xfer_allow = 2'b01;
    repeat (2) @(negedge i_clk);
    check("request 0 on", 16'(o_chan0_xfer_request_n), 16'h0);
    // drain to empty, memory stalling a random while on each word
    for (int k = 0; k < 32; k++) begin
      dmac.xfer(0, 1'b0, 3 + $urandom % 6, 16'h0000, got, ok);
      check("output handshake", 16'(ok), 16'h1);
      check("word to memory", got, q.pop_front());
    end
    check("request 0 empty", 16'(o_chan0_xfer_request_n), 16'h1);
    i_chan_xfer_allow = 2'b10;
    i_rx_request = 1'b1;
    repeat (2) @(negedge i_clk);
    check("request 1 on", 16'(o_chan1_xfer_request_n), 16'h0);
    for (int k = 0; k < 6; k++) begin
      w = 16'($urandom);
      dmac.xfer(1, 1'b1, 0, w, got, ok);
      check("input handshake", 16'(ok), 16'h1);
      check("word from memory", rx_seen, w);
    end
    dmac.cut(1, 5);
    check("words after abort", 16'(rx_cnt), 16'd6);
    i_chan_xfer_allow = 2'b00;
    repeat (2) @(negedge i_clk);
    check("request 1 off", 16'(o_chan1_xfer_request_n), 16'h1);
    for (int k = 0; k < 2; k++) begin
      dmac.reg_cycle(k[0], ok);
      check("register ack", 16'(ok), 16'h1);
    end
    dmac.finish_block;
    repeat (4) @(negedge i_clk);
    check("block done", 16'(done_cnt), 16'd1);
    report_and_stop;
  end
  // the sequence needs about 1000 cycles; this leaves ample margin
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule
